// >>> rtl/scri_pkg.sv
// package: constants and types of the system control, reset and interrupt block
package scri_pkg;

    // register byte offsets
    localparam logic [7:0] SCRI_OFS_OPTS    = 8'h20;
    localparam logic [7:0] SCRI_OFS_SRC_EN  = 8'h24;
    localparam logic [7:0] SCRI_OFS_STATUS  = 8'h28;
    localparam logic [7:0] SCRI_OFS_VECTOR  = 8'h2c;

    // option register fields and reset value
    localparam int         SCRI_OPT_SLOW    = 0;
    localparam int         SCRI_OPT_PRE_LSB = 1;
    localparam int         SCRI_OPT_SEN_LSB = 3;
    localparam logic [4:0] SCRI_OPTS_RESET  = 5'h00;
    localparam logic [9:0] SCRI_SRC_RESET   = 10'h000;

    // sensitivity codes, written as {b4,b3}
    localparam logic [1:0] SCRI_SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] SCRI_SENS_RISE     = 2'h1;
    localparam logic [1:0] SCRI_SENS_FALL     = 2'h2;

    // divider terminal counts (divide-by minus one), prescaler written as {b2,b1}
    localparam logic [4:0] SCRI_DIV2_LAST  = 5'h01;
    localparam logic [4:0] SCRI_DIV4_LAST  = 5'h03;
    localparam logic [4:0] SCRI_DIV8_LAST  = 5'h07;
    localparam logic [4:0] SCRI_DIV16_LAST = 5'h0f;
    localparam logic [4:0] SCRI_DIV32_LAST = 5'h1f;

    // timing counts: reset length in cpu clock cycles, pin blanking in i_mclk cycles
    localparam int         SCRI_RESET_CYCLES = 4096;
    localparam logic [1:0] SCRI_BLANK_CYCLES = 2'h3;

    // vectors
    localparam logic [15:0] SCRI_VEC_RESET  = 16'hfffe;
    localparam logic [15:0] SCRI_VEC_TRAP   = 16'hfffc;
    localparam logic [15:0] SCRI_VEC_LEVEL0 = 16'hfffa;
    localparam int          SCRI_NUM_LEVELS = 13;

    // bus answers
    localparam logic [1:0] SCRI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SCRI_RESP_SLVERR = 2'h2;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SCRI_ST_RESET = 4'b0001,
        SCRI_ST_RUN   = 4'b0010,
        SCRI_ST_HALT  = 4'b0100,
        SCRI_ST_STAB  = 4'b1000
    } scri_state_t;

    // peripheral interrupt flags, all active high levels
    typedef struct packed {
        logic       can_rx_flag;
        logic       can_tx_flag;
        logic       can_error_pending;
        logic       bridge_short_flag;
        logic       overtemp_flag;
        logic [1:0] t1_compare;
        logic [1:0] t1_capture;
        logic       t1_overflow;
        logic [1:0] t2_compare;
        logic [1:0] t2_capture;
        logic       t2_overflow;
        logic       adc_end;
        logic       pwm1_overflow;
        logic       pwm2_overflow;
        logic       eeprom_prog_irq;
    } scri_periph_t;

    // reset causes, sticky
    typedef struct packed {
        logic ext_pin;
        logic supply;
        logic watchdog;
        logic safeguard;
    } scri_cause_t;

endpackage : scri_pkg

// >>> rtl/scri_top.sv
// system control: cpu clock divider, reset sequencer, interrupt priority and vectors
`timescale 1ns/1ps

// Contract
// - bit zero clear selects oscillator divided by two
// - slow prescaler picks divide by 4/8/16/32
// - sensitivity field picks edge or level trigger
// - sensitivity applies to all ten port lines
// - sensitivity writes only while cpu mask set
// - four reset sources: pin, supply, watchdog, safeguard
// - leaving reset fetches the top reset vector
// - internal reset drives reset pin low
// - reset lasts 4096 cpu cycles, pin mirrors it
// - external low of 1.5 cycles is recognised
// - held external pin keeps device in reset
// - power-on and halt exit wait 4096 cycles
// - supply below threshold holds static reset
// - fixed priority, level zero highest
// - thirteen levels mapped to fixed sources
// - only levels zero and one wake halt
// - enabled pins of a group are ORed
// - vectors descend two bytes per level
// - shared flags of a level share one vector
module scri_top
    import scri_pkg::*;
#(
    parameter int RESET_CYCLES = SCRI_RESET_CYCLES
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    // axi4-lite slave
    input  wire logic [7:0]   i_s_axi_awaddr,
    input  wire logic         i_s_axi_awvalid,
    output logic              o_s_axi_awready,
    input  wire logic [31:0]  i_s_axi_wdata,
    input  wire logic [3:0]   i_s_axi_wstrb,
    input  wire logic         i_s_axi_wvalid,
    output logic              o_s_axi_wready,
    output logic [1:0]        o_s_axi_bresp,
    output logic              o_s_axi_bvalid,
    input  wire logic         i_s_axi_bready,
    input  wire logic [7:0]   i_s_axi_araddr,
    input  wire logic         i_s_axi_arvalid,
    output logic              o_s_axi_arready,
    output logic [31:0]       o_s_axi_rdata,
    output logic [1:0]        o_s_axi_rresp,
    output logic              o_s_axi_rvalid,
    input  wire logic         i_s_axi_rready,
    // core side
    input  wire logic         i_cc_irq_mask,
    input  wire logic         i_halt_req,
    input  wire logic         i_sw_trap,
    input  wire logic         i_irq_ack,
    output logic              o_cpu_clk,
    output logic              o_cpu_reset_n,
    output logic              o_cpu_run,
    output logic              o_osc_enable,
    output logic              o_irq_req,
    output logic [3:0]        o_irq_level,
    output logic [15:0]       o_vector,
    // reset sources and pins
    input  wire logic         i_supply_low_reset,
    input  wire logic         i_watchdog_reset,
    input  wire logic         i_safeguard_reset,
    input  wire logic         i_ext_reset_pin_n,
    output logic              o_ext_reset_pin_n_o,
    output logic              o_ext_reset_pin_n_oe,
    // interrupt sources
    input  wire logic [7:0]   i_port_a_lines,
    input  wire logic [1:0]   i_port_b_lines,
    input  wire scri_periph_t i_periph
);

    initial begin
        if (RESET_CYCLES < 2 || RESET_CYCLES > 8192)
            $error("RESET_CYCLES out of the counter range");
    end

    localparam logic [12:0] CNT_LAST = 13'(RESET_CYCLES - 1);

    // divider terminal count from the option bits
    function automatic logic [4:0] div_last(input logic [4:0] opts);
        logic [1:0] pre;
        pre = opts[SCRI_OPT_PRE_LSB +: 2];
        if (!opts[SCRI_OPT_SLOW])
            return SCRI_DIV2_LAST;
        unique case (pre)
            2'h0:    return SCRI_DIV4_LAST;
            2'h2:    return SCRI_DIV8_LAST;
            2'h1:    return SCRI_DIV16_LAST;
            default: return SCRI_DIV32_LAST;
        endcase
    endfunction

    // lowest set index wins; msb of the result flags any pending level
    function automatic logic [4:0] top_level(input logic [SCRI_NUM_LEVELS-1:0] lv);
        logic [4:0] r;
        r = 5'h00;
        for (int k = SCRI_NUM_LEVELS - 1; k >= 0; k--) begin
            if (lv[k])
                r = {1'b1, 4'(k)};
        end
        return r;
    endfunction

    // level n sits two bytes below level n-1
    function automatic logic [15:0] level_vec(input logic [3:0] lvl);
        return SCRI_VEC_LEVEL0 - {11'h000, lvl, 1'b0};
    endfunction

    scri_state_t  state_reg, state_next;
    logic [4:0]   opts_reg;
    logic [9:0]   src_en_reg;
    logic [4:0]   div_cnt_reg, div_cur_reg;
    logic [12:0]  cnt_reg;
    logic [1:0]   blank_reg;
    logic         tick;
    scri_cause_t  cause_reg, cause_now;
    logic [1:0]   sup_sync_reg, pin_sync_reg;
    logic [9:0]   port_s1_reg, port_s2_reg;
    logic         grp_low_prev_reg, ext_pend_reg;
    logic         grp_low, ext_edge, any_req;
    logic [SCRI_NUM_LEVELS-1:0] lv;
    logic [4:0]   top;
    logic         wr_fire, rd_fire, wr_opts, wr_src, clr_cause;

    // pins pass two flops before any logic looks at them
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sup_sync_reg <= 2'h3;
            pin_sync_reg <= 2'h3;
            port_s1_reg  <= 10'h3ff;
            port_s2_reg  <= 10'h3ff;
        end else begin
            sup_sync_reg <= {sup_sync_reg[0], i_supply_low_reset};
            pin_sync_reg <= {pin_sync_reg[0], i_ext_reset_pin_n};
            port_s1_reg  <= {i_port_b_lines, i_port_a_lines};
            port_s2_reg  <= port_s1_reg;
        end
    end

    // cpu clock divider; the new ratio loads only at the wrap so no pulse is cut short
    assign tick = (div_cnt_reg == div_cur_reg);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt_reg <= 5'h00;
            div_cur_reg <= SCRI_DIV2_LAST;
            o_cpu_clk   <= 1'b0;
        end else begin
            if (tick) begin
                div_cnt_reg <= 5'h00;
                div_cur_reg <= div_last(opts_reg);
            end else begin
                div_cnt_reg <= div_cnt_reg + 5'h01;
            end
            // low for the first half of each period, high for the second
            o_cpu_clk <= tick ? 1'b0 : (div_cnt_reg >= (div_cur_reg >> 1));
        end
    end

    // reset requests; the pin is ignored while driven and a few cycles after
    // four reset sources
    // one synced low sample is enough
    always_comb begin
        cause_now.ext_pin   = !pin_sync_reg[1] && (blank_reg == 2'h0);
        cause_now.supply    = sup_sync_reg[1];
        cause_now.watchdog  = i_watchdog_reset;
        cause_now.safeguard = i_safeguard_reset;
    end
    assign any_req = |cause_now;

    // pin blanking hides our own drive coming back through the synchroniser
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            blank_reg <= SCRI_BLANK_CYCLES;
        else if (o_ext_reset_pin_n_oe)
            blank_reg <= SCRI_BLANK_CYCLES;
        else if (blank_reg != 2'h0)
            blank_reg <= blank_reg - 2'h1;
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCRI_ST_RESET: begin
                if (!any_req && cnt_reg == CNT_LAST && blank_reg == 2'h0)
                    state_next = SCRI_ST_RUN;
            end
            SCRI_ST_RUN: begin
                if (any_req)
                    state_next = SCRI_ST_RESET;
                else if (i_halt_req)
                    state_next = SCRI_ST_HALT;
            end
            SCRI_ST_HALT: begin
                if (any_req)
                    state_next = SCRI_ST_RESET;
                // wake on level zero or one
                else if (lv[0] || lv[1])
                    state_next = SCRI_ST_STAB;
            end
            SCRI_ST_STAB: begin
                if (any_req)
                    state_next = SCRI_ST_RESET;
                else if (tick && cnt_reg == CNT_LAST)
                    state_next = SCRI_ST_RUN;
            end
            default: state_next = SCRI_ST_RESET;
        endcase
    end

    // state, one shared length counter and the registered core controls
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg            <= SCRI_ST_RESET;
            cnt_reg              <= 13'h0000;
            o_cpu_reset_n        <= 1'b0;
            o_cpu_run            <= 1'b0;
            o_osc_enable         <= 1'b1;
            o_ext_reset_pin_n_oe <= 1'b1;
            o_ext_reset_pin_n_o  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (any_req || state_reg != state_next)
                cnt_reg <= 13'h0000;
            else if (tick && cnt_reg != CNT_LAST)
                cnt_reg <= cnt_reg + 13'h0001;
            o_cpu_reset_n <= (state_next != SCRI_ST_RESET);
            o_cpu_run     <= (state_next == SCRI_ST_RUN);
            o_osc_enable  <= (state_next != SCRI_ST_HALT);
            // pin pulled low until the reset count completes
            o_ext_reset_pin_n_oe <= state_next == SCRI_ST_RESET && (any_req || cnt_reg != CNT_LAST);
            o_ext_reset_pin_n_o  <= 1'b0;
        end
    end

    // port group: any enabled line low counts, the group behaves as one wire
    // enabled pins combined
    // one sensitivity for all ten lines
    assign grp_low = |(src_en_reg & ~port_s2_reg);
    always_comb begin
        unique case (opts_reg[SCRI_OPT_SEN_LSB +: 2])
            SCRI_SENS_RISE: ext_edge = grp_low_prev_reg && !grp_low;
            SCRI_SENS_FALL: ext_edge = !grp_low_prev_reg && grp_low;
            SCRI_SENS_FALL_LOW: ext_edge = !grp_low_prev_reg && grp_low;
            default:        ext_edge = grp_low_prev_reg != grp_low;
        endcase
    end

    // latched edge; a new edge in the ack cycle survives
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            grp_low_prev_reg <= 1'b0;
            ext_pend_reg     <= 1'b0;
        end else begin
            grp_low_prev_reg <= grp_low;
            if (ext_edge)
                ext_pend_reg <= 1'b1;
            else if (i_irq_ack && o_irq_level == 4'h0)
                ext_pend_reg <= 1'b0;
        end
    end

    // level map; shared flags are ORed onto their level
    // source to level map
    always_comb begin
        lv[0]  = ext_pend_reg
               || (opts_reg[SCRI_OPT_SEN_LSB +: 2] == SCRI_SENS_FALL_LOW && grp_low);
        lv[1]  = i_periph.can_rx_flag || i_periph.can_tx_flag || i_periph.can_error_pending;
        lv[2]  = i_periph.bridge_short_flag || i_periph.overtemp_flag;
        lv[3]  = |i_periph.t1_compare;
        lv[4]  = |i_periph.t1_capture;
        lv[5]  = i_periph.t1_overflow;
        lv[6]  = |i_periph.t2_compare;
        lv[7]  = |i_periph.t2_capture;
        lv[8]  = i_periph.t2_overflow;
        lv[9]  = i_periph.adc_end;
        lv[10] = i_periph.pwm1_overflow;
        lv[11] = i_periph.pwm2_overflow;
        lv[12] = i_periph.eeprom_prog_irq;
    end
    assign top = top_level(lv);

    // request and vector toward the core
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_req   <= 1'b0;
            o_irq_level <= 4'h0;
            o_vector    <= SCRI_VEC_RESET;
        end else begin
            o_irq_req   <= top[4] && (state_next == SCRI_ST_RUN);
            o_irq_level <= top[3:0];
            if (state_next == SCRI_ST_RESET)
                o_vector <= SCRI_VEC_RESET;
            else if (i_sw_trap)
                o_vector <= SCRI_VEC_TRAP;
            else
                o_vector <= level_vec(top[3:0]);
        end
    end

    // bus handshakes: ready is a one-cycle pulse once both write channels are offered
    assign wr_fire = o_s_axi_awready && i_s_axi_awvalid && o_s_axi_wready && i_s_axi_wvalid;
    assign rd_fire = o_s_axi_arready && i_s_axi_arvalid;
    assign wr_opts = wr_fire && i_s_axi_awaddr == SCRI_OFS_OPTS && i_s_axi_wstrb[0];
    assign wr_src  = wr_fire && i_s_axi_awaddr == SCRI_OFS_SRC_EN;
    assign clr_cause = wr_fire && i_s_axi_awaddr == SCRI_OFS_STATUS && i_s_axi_wstrb[0];

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= SCRI_RESP_OKAY;
        end else begin
            o_s_axi_awready <= !o_s_axi_awready && i_s_axi_awvalid && i_s_axi_wvalid
                               && !o_s_axi_bvalid;
            o_s_axi_wready  <= !o_s_axi_wready && i_s_axi_awvalid && i_s_axi_wvalid
                               && !o_s_axi_bvalid;
            if (wr_fire) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= (i_s_axi_awaddr == SCRI_OFS_OPTS
                                   || i_s_axi_awaddr == SCRI_OFS_SRC_EN
                                   || i_s_axi_awaddr == SCRI_OFS_STATUS
                                   || i_s_axi_awaddr == SCRI_OFS_VECTOR)
                                  ? SCRI_RESP_OKAY : SCRI_RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable registers; the sensitivity bits hold unless the cpu mask is set
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            opts_reg   <= SCRI_OPTS_RESET;
            src_en_reg <= SCRI_SRC_RESET;
        end else begin
            if (wr_opts) begin
                opts_reg[2:0] <= i_s_axi_wdata[2:0];
                if (i_cc_irq_mask)
                    opts_reg[4:3] <= i_s_axi_wdata[4:3];
            end
            if (wr_src && i_s_axi_wstrb[0])
                src_en_reg[7:0] <= i_s_axi_wdata[7:0];
            if (wr_src && i_s_axi_wstrb[1])
                src_en_reg[9:8] <= i_s_axi_wdata[9:8];
        end
    end

    // reset causes are sticky; write one clears, a new cause in that cycle wins
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            cause_reg <= '0;
        else
            cause_reg <= cause_now
                       | (cause_reg & ~(clr_cause ? scri_cause_t'(i_s_axi_wdata[3:0]) : '0));
    end

    // read channel
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h0000_0000;
            o_s_axi_rresp   <= SCRI_RESP_OKAY;
        end else begin
            o_s_axi_arready <= !o_s_axi_arready && i_s_axi_arvalid && !o_s_axi_rvalid;
            if (rd_fire) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp  <= SCRI_RESP_OKAY;
                unique case (i_s_axi_araddr)
                    SCRI_OFS_OPTS:   o_s_axi_rdata <= {27'h0, opts_reg};
                    SCRI_OFS_SRC_EN: o_s_axi_rdata <= {22'h0, src_en_reg};
                    SCRI_OFS_STATUS: o_s_axi_rdata <= {24'h0, state_reg, cause_reg};
                    SCRI_OFS_VECTOR: o_s_axi_rdata <= {11'h0, top, level_vec(top[3:0])};
                    default: begin
                        o_s_axi_rdata <= 32'h0000_0000;
                        o_s_axi_rresp <= SCRI_RESP_SLVERR;
                    end
                endcase
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    sequence s_guarded_write;
        wr_opts && !i_cc_irq_mask;
    endsequence
    sequence s_reset_done;
        state_reg == SCRI_ST_RESET && state_next == SCRI_ST_RUN;
    endsequence

    a_div_boundary: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(div_cur_reg) |-> $past(tick)) else $error("divider changed mid period");
    a_sens_locked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_guarded_write |=> $stable(opts_reg[4:3])) else $error("sensitivity written unmasked");
    a_reset_length: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_reset_done |-> cnt_reg == CNT_LAST && !o_ext_reset_pin_n_oe) else $error("reset ended early");
    a_pin_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == SCRI_ST_RESET && cnt_reg != CNT_LAST
        |-> o_ext_reset_pin_n_oe && !o_cpu_reset_n)
        else $error("reset pin not driven");
    a_reset_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        any_req |=> state_reg == SCRI_ST_RESET && cnt_reg == 13'h0000)
        else $error("request did not restart reset");
    a_halt_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == SCRI_ST_HALT && state_next == SCRI_ST_STAB |-> lv[0] || lv[1])
        else $error("halt left by wrong level");
    a_vector_map: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_next == SCRI_ST_RUN && !i_sw_trap && top[4]
        |=> o_vector == 16'hfffa - {11'h000, $past(top[3:0]), 1'b0})
        else $error("vector does not match level");
    a_priority_top: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        top[4] |-> lv[top[3:0]] && (lv & ((13'h0001 << top[3:0]) - 13'h0001)) == 13'h0000)
        else $error("lower level chosen over higher");
    a_normal_div: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !opts_reg[SCRI_OPT_SLOW] && tick |=> div_cur_reg == SCRI_DIV2_LAST)
        else $error("normal mode not divide by two");
    a_reset_vector: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == SCRI_ST_RESET |-> o_vector == 16'hfffe) else $error("reset vector wrong");

endmodule : scri_top

// >>> tb/scri_core_model.sv
// core model: answers each pending interrupt after a short service delay
`timescale 1ns/1ps
module scri_core_model (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_irq_req,
    output logic      o_irq_ack
);
    logic [1:0] wait_reg;  // cycles the request has stood unanswered
    // one ack pulse, then a fresh wait so a request is never taken twice
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg  <= 2'h0;
            o_irq_ack <= 1'h0;
        end else begin
            o_irq_ack <= i_irq_req && (wait_reg == 2'h3);
            wait_reg  <= (i_irq_req && !o_irq_ack) ? wait_reg + 2'h1 : 2'h0;
        end
    end
endmodule // scri_core_model

// >>> tb/tb.sv
// testbench: reset sources, registers, cpu clock, interrupts and halt
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import scri_pkg::*;
    localparam int RC = 8;  // short reset count keeps the run brief
    logic i_mclk = 0, i_rst_n = 0, i_cc_irq_mask = 1, i_halt_req = 0, i_sw_trap = 0, ack;
    logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0, ext_n = 1;
    logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_supply_low_reset = 0;
    logic i_watchdog_reset = 0, i_safeguard_reset = 0;
    logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, i_port_a_lines = '1;
    logic [31:0] i_s_axi_wdata = 0, rd, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb = '1, o_irq_level;
    logic [1:0] i_port_b_lines = '1, resp, o_s_axi_bresp, o_s_axi_rresp;
    scri_periph_t i_periph = '0;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic o_cpu_clk, o_cpu_reset_n, o_cpu_run, o_osc_enable, o_irq_req;
    logic o_ext_reset_pin_n_o, o_ext_reset_pin_n_oe;
    logic [15:0] o_vector;
    int error_cnt = 0, n_compared = 0, n;
    // open-drain pin with pull-up: low while either side pulls it
    wire pin_n = (o_ext_reset_pin_n_oe && !o_ext_reset_pin_n_o) ? 1'b0 : ext_n;
    always #50 i_mclk = ~i_mclk;
    scri_top #(.RESET_CYCLES(RC)) dut_u (.*, .i_ext_reset_pin_n(pin_n), .i_irq_ack(ack));
    scri_core_model core_u (.i_mclk, .i_rst_n, .i_irq_req(o_irq_req), .o_irq_ack(ack));
    task automatic ck(input int k);
        repeat (k) @(posedge i_mclk);
    endtask
    // bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {i_s_axi_awaddr, i_s_axi_wdata} <= {a, d};
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= '1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (o_s_axi_bvalid !== 1'b1);
        i_s_axi_bready <= 1'b0;
        resp = o_s_axi_bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge i_mclk);
        i_s_axi_araddr <= a;
        {i_s_axi_arvalid, i_s_axi_rready} <= '1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (o_s_axi_rvalid !== 1'b1);
        i_s_axi_rready <= 1'b0;
        {rd, resp} = {o_s_axi_rdata, o_s_axi_rresp};
    endtask
    // each source in turn: pin pulled, vector, length, sticky cause
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            wr(SCRI_OFS_STATUS, 32'hf);
            {ext_n, i_supply_low_reset, i_watchdog_reset, i_safeguard_reset} <= (4'h1 << i) ^ 4'h8;
            ck(i == 2 ? 40 : 3);
            {ext_n, i_supply_low_reset, i_watchdog_reset, i_safeguard_reset} <= 4'h8;
            ck(3);
            `CHK("pin_low", 1'h1, o_ext_reset_pin_n_oe)
            `CHK("rst_vec", SCRI_VEC_RESET, o_vector)
            for (n = 3; n < 99 && o_cpu_reset_n !== 1'b1; n++) @(posedge i_mclk);
            `CHK("rst_len", 1'h1, n >= 2 * RC && n <= 2 * RC + 12)
            `CHK("pin_free", 1'h0, o_ext_reset_pin_n_oe)
            rdr(SCRI_OFS_STATUS);
            `CHK("cause", 8'h20 | 8'(1 << i), rd[7:0])
        end
    endtask
    // option register: reset value, guarded field, unmapped place
    task automatic t_regs();
        rdr(SCRI_OFS_OPTS);
        `CHK("opt_rst", 32'h0, rd)
        wr(SCRI_OFS_OPTS, 32'h1e);
        i_cc_irq_mask <= 1'b0;
        wr(SCRI_OFS_OPTS, 32'h0);
        rdr(SCRI_OFS_OPTS);
        `CHK("opt_guard", 32'h18, rd)
        i_cc_irq_mask <= 1'b1;
        rdr(8'h40);
        `CHK("bad_rd", {SCRI_RESP_SLVERR, 32'h0}, {resp, rd})
        wr(8'h44, 32'h0);
        `CHK("bad_wr", SCRI_RESP_SLVERR, resp)
    endtask
    // cpu clock period for normal mode and every prescaler code
    task automatic t_div();
        logic [4:0] code [5] = '{5'h0, 5'h1, 5'h5, 5'h3, 5'h7};
        int len [5] = '{2, 4, 8, 16, 32};
        for (int i = 0; i < 5; i++) begin
            wr(SCRI_OFS_OPTS, {27'h0, code[i]});
            repeat (3) begin
                for (n = 0; n < 99 && o_cpu_clk !== 1'b0; n++) @(posedge i_mclk);
                for (n = 0; n < 99 && o_cpu_clk !== 1'b1; n++) @(posedge i_mclk);
            end
            for (n = 0; n < 99 && o_cpu_clk === 1'b1; n++) @(posedge i_mclk);
            for (; n < 99 && o_cpu_clk === 1'b0; n++) @(posedge i_mclk);
            `CHK("cpu_period", len[i], n)
        end
        wr(SCRI_OFS_OPTS, 32'h0);
    endtask
    // port group: enable mask, OR of lines, the four trigger choices
    task automatic t_port();
        wr(SCRI_OFS_SRC_EN, 32'h108);
        wr(SCRI_OFS_OPTS, 32'h10);
        i_port_a_lines[0] <= 1'b0;
        ck(12);
        `CHK("not_enabled", 1'h0, o_irq_req)
        i_port_b_lines[0] <= 1'b0;
        ck(6);
        `CHK("lv0", {5'h10, SCRI_VEC_LEVEL0}, {o_irq_req, o_irq_level, o_vector})
        ck(12);
        `CHK("fall_once", 1'h0, o_irq_req)
        wr(SCRI_OFS_OPTS, 32'h0);
        ck(6);
        `CHK("low_level", 1'h1, o_irq_req)
        wr(SCRI_OFS_OPTS, 32'h08);
        i_port_b_lines[0] <= 1'b1;
        ck(6);
        `CHK("rise", 1'h1, o_irq_req)
        wr(SCRI_OFS_OPTS, 32'h18);
        i_port_a_lines <= 8'hf7;
        ck(6);
        `CHK("both", 1'h1, o_irq_req)
        i_port_a_lines <= 8'hff;
        wr(SCRI_OFS_OPTS, 32'h10);
        ck(12);
    endtask
    // one flag at a time: its level and vector; then the top one wins
    task automatic t_prio();
        int lv [19] = '{12, 11, 10, 9, 8, 7, 7, 6, 6, 5, 4, 4, 3, 3, 2, 2, 1, 1, 1};
        for (int b = 0; b < 19; b++) begin
            i_periph <= scri_periph_t'(19'h1 << b);
            ck(3);
            `CHK("level", 4'(lv[b]), o_irq_level)
            `CHK("vector", SCRI_VEC_LEVEL0 - 16'(2 * lv[b]), o_vector)
        end
        {i_periph, i_sw_trap} <= '1;
        ck(3);
        `CHK("top_trap", {4'h1, SCRI_VEC_TRAP}, {o_irq_level, o_vector})
        {i_periph, i_sw_trap} <= '0;
        ck(3);
    endtask
    // halt: a low level does not wake, level one does after the wait
    task automatic t_halt();
        i_halt_req <= 1'b1;
        ck(1);
        i_halt_req <= 1'b0;
        i_periph.adc_end <= 1'b1;
        ck(30);
        `CHK("halted", 2'h0, {o_cpu_run, o_osc_enable})
        i_periph.can_rx_flag <= 1'b1;
        for (n = 0; n < 200 && o_cpu_run !== 1'b1; n++) @(posedge i_mclk);
        `CHK("wake", 1'h1, n >= 2 * RC && n < 200)
        i_periph <= '0;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        ck(8);
        i_rst_n <= 1'b1;
        ck(2);
        `CHK("por", {1'h1, SCRI_VEC_RESET}, {o_ext_reset_pin_n_oe, o_vector})
        for (n = 2; n < 200 && o_cpu_reset_n !== 1'b1; n++) @(posedge i_mclk);
        `CHK("por_wait", 1'h1, n >= 2 * RC && n < 200)
        t_reset();
        t_regs();
        t_div();
        t_port();
        t_prio();
        t_halt();
        results();
    end
    // a hang counts as a mismatch and ends the run the usual way
    initial begin
        #2000000;
        error_cnt++;
        results();
    end
endmodule // tb
